/* logic/stp_pkg.sv */
// Purpose: shared constants and types for the serial test port
// Assumes: 16-bit registers on a plain strobe port, baud ticks from an outside timer
// Notes: all offsets, keys, field positions and reset values live here
//
// What this block does
// - Diagnostic data leaves on one output pin only, with no receive path and no clock line.
// - A transmission carries one to six bytes, each sent as its own 12-bit packet.
// - A packet is a start bit, eight data bits, a parity bit and two stop bits, in order.
// - Bit timing advances once per baud timer overflow, so the line rate is that rate.
// - A control write not preceded by a correct first key is ignored.
// - A control write not followed by a correct second key is discarded, old value kept.
// - The first data register gives byte one from bits 7:0 and byte two from bits 15:8.
// - The second data register gives byte three low and byte four high.
// - The third data register gives byte five low and byte six high.
// - Control bits 4:2 hold the byte count, codes 000 to 101 meaning one to six bytes.
// - Control bit 0 enables the port; setting bit 1 resets it and control then reads zero.
// - Once enabled, sending waits until all data registers the count needs are written.
// - Control bits 8:5 read nonzero while a transmission runs and zero when it ends.

package stp_pkg;

    // ==========================================================
    // register map
    localparam logic [31:0] STP_ADDR_UNLOCK_FIRST = 32'hffff_0880;
    localparam logic [31:0] STP_ADDR_CONTROL = 32'hffff_0884;
    localparam logic [31:0] STP_ADDR_UNLOCK_SECOND = 32'hffff_0888;
    localparam logic [31:0] STP_ADDR_BYTES_ONE_TWO = 32'hffff_088c;
    localparam logic [31:0] STP_ADDR_BYTES_THREE_FOUR = 32'hffff_0890;
    localparam logic [31:0] STP_ADDR_BYTES_FIVE_SIX = 32'h0fff_0894;

    // ==========================================================
    // key values and reset values
    localparam logic [15:0] STP_KEY_FIRST = 16'h0007;
    localparam logic [15:0] STP_KEY_SECOND = 16'h00b9;
    localparam logic [15:0] STP_CTRL_RESET = 16'h0000;
    localparam logic [15:0] STP_DATA_RESET = 16'h0000;

    // ==========================================================
    // control field positions
    localparam int STP_CTRL_EN_BIT = 0;
    localparam int STP_CTRL_RST_BIT = 1;
    localparam int STP_CTRL_CNT_LSB = 2;
    localparam int STP_CTRL_STATE_LSB = 5;

    // ==========================================================
    // packet and transfer sizes
    localparam logic [3:0] STP_FRAME_BITS = 4'd12;
    localparam int STP_NUM_DATA_REGS = 3;
    localparam logic [2:0] STP_MAX_COUNT_CODE = 3'd5;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [2:0] count;
        logic port_reset;
        logic enable;
    } stp_ctrl_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } stp_bus_req_s;

    typedef enum logic [1:0] {
        STP_ST_IDLE,
        STP_ST_SEND,
        STP_ST_DRAIN
    } stp_state_e;

    // unpack a written control word
    function automatic stp_ctrl_s stp_ctrl_from_word(input logic [15:0] w);
        stp_ctrl_s c;
        c.enable = w[STP_CTRL_EN_BIT];
        c.port_reset = w[STP_CTRL_RST_BIT];
        c.count = w[STP_CTRL_CNT_LSB +: 3];
        return c;
    endfunction : stp_ctrl_from_word

endpackage : stp_pkg

/* logic/stp_packet_shift.sv */
// Purpose: serialise one byte as a 12-bit packet on the baud tick
// Assumes: baud_tick is a one-cycle pulse from the baud timer
// Notes: ready rises as the last stop bit goes out, so a new load is gapless
`timescale 1ns/100ps

module stp_packet_shift
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // control
    input wire logic clear,
    input wire logic baud_tick,
    input wire logic load,
    input wire logic [7:0] load_byte,
    // status and line
    output logic ready,
    output logic idle,
    output logic tx_line
);
    import stp_pkg::*;

    logic [11:0] frame_q;
    logic [3:0] left_q;
    logic hold_q;
    logic line_q;

    // frame loading and shifting
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || clear)
        begin
            frame_q <= '0;
            left_q <= '0;
        end
        else if (load && left_q == 4'd0)
        begin
            frame_q <= {2'b11, ^load_byte, load_byte, 1'b0};
            left_q <= STP_FRAME_BITS;
        end
        else if (baud_tick && left_q != 4'd0)
        begin
            frame_q <= {1'b1, frame_q[11:1]}; // lsb first
            left_q <= left_q - 4'd1;
        end
    end

    // line drive, changes only on a tick, or goes high on reset or clear
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || clear)
            line_q <= 1'b1; // idle high
        else if (baud_tick && left_q != 4'd0)
            line_q <= frame_q[0];
    end

    // last stop bit still on the line
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || clear)
            hold_q <= 1'b0;
        else if (baud_tick)
            hold_q <= (left_q == 4'd1);
    end

    assign ready = (left_q == 4'd0);
    assign idle = ready && !hold_q;
    assign tx_line = line_q; // single pin

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn || clear);

    property p_start_bit;
        baud_tick && left_q == STP_FRAME_BITS |=> !tx_line;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not low");

    property p_stop_bits;
        baud_tick && (left_q == 4'd1 || left_q == 4'd2) |=> tx_line;
    endproperty
    a_stop_bits: assert property (p_stop_bits) else $error("stop bit not high");

    property p_even_parity;
        load && ready |=> frame_q[9] == ^$past(load_byte);
    endproperty
    a_even_parity: assert property (p_even_parity) else $error("parity not even");

    property p_tick_paced;
        !baud_tick |=> $stable(tx_line);
    endproperty
    a_tick_paced: assert property (p_tick_paced) else $error("line moved off tick");

endmodule : stp_packet_shift

/* logic/stp_serial_test_port.sv */
// Purpose: key-protected transmit-only serial test port
// Assumes: bus strobes one cycle long, baud ticks from the baud timer
// Notes: control reads back its stored value with live state in bits 8:5
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps

module stp_serial_test_port
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input stp_pkg::stp_bus_req_s bus_req,
    output logic [15:0] rdata,
    // baud timer overflow
    input wire logic baud_tick,
    // serial pin
    output logic test_line
);
    import stp_pkg::*;

    // ==========================================================
    // decode helpers

    // index of the last byte for a count code, illegal codes act as six
    function automatic logic [2:0] last_index(input logic [2:0] code);
        return (code > STP_MAX_COUNT_CODE) ? STP_MAX_COUNT_CODE : code;
    endfunction : last_index

    // data registers a count code needs written
    function automatic logic [2:0] regs_needed(input logic [2:0] code);
        logic [2:0] li;
        li = last_index(code);
        unique case (li[2:1])
            2'd0: return 3'b001;
            2'd1: return 3'b011;
            default: return 3'b111;
        endcase
    endfunction : regs_needed

    // ==========================================================
    // access decode
    logic wr_key_first;
    logic wr_key_second;
    logic wr_control;
    logic any_access;
    logic [2:0] wr_data;

    assign wr_key_first = bus_req.wr && bus_req.addr == STP_ADDR_UNLOCK_FIRST;
    assign wr_key_second = bus_req.wr && bus_req.addr == STP_ADDR_UNLOCK_SECOND;
    assign wr_control = bus_req.wr && bus_req.addr == STP_ADDR_CONTROL;
    assign any_access = bus_req.wr || bus_req.rd;
    assign wr_data[0] = bus_req.wr && bus_req.addr == STP_ADDR_BYTES_ONE_TWO;
    assign wr_data[1] = bus_req.wr && bus_req.addr == STP_ADDR_BYTES_THREE_FOUR;
    assign wr_data[2] = bus_req.wr && bus_req.addr == STP_ADDR_BYTES_FIVE_SIX;

    // ==========================================================
    // unlock sequence
    logic key_armed_q;
    logic pend_q;
    stp_ctrl_s pend_val_q;
    logic commit;
    logic port_clr;

    // first key arms exactly the next access
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            key_armed_q <= 1'b0;
        else if (any_access)
            key_armed_q <= wr_key_first && bus_req.wdata == STP_KEY_FIRST;
    end

    // control write held until the second key is seen
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pend_q <= 1'b0;
            pend_val_q <= '0;
        end
        else if (any_access)
        begin
            pend_q <= wr_control && key_armed_q; // unarmed write ignored
            if (wr_control)
                pend_val_q <= stp_ctrl_from_word(bus_req.wdata);
        end
    end

    // any other next access drops the pending write
    assign commit = pend_q && wr_key_second && bus_req.wdata == STP_KEY_SECOND;
    assign port_clr = commit && pend_val_q.port_reset;

    // ==========================================================
    // control register
    stp_ctrl_s ctrl_q;

    // only a completed sequence changes control
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            ctrl_q <= stp_ctrl_from_word(STP_CTRL_RESET);
        else if (port_clr)
            ctrl_q <= '0; // port reset reads back zero
        else if (commit)
            ctrl_q <= pend_val_q;
    end

    // ==========================================================
    // data holding registers
    logic [15:0] data_q [STP_NUM_DATA_REGS];
    logic [2:0] written_q;
    logic start;

    generate
        for (genvar i = 0; i < STP_NUM_DATA_REGS; i++)
        begin : g_data
            // one holding register, two bytes
            always_ff @(posedge clk_sys)
            begin
                if (!resetn || port_clr)
                    data_q[i] <= STP_DATA_RESET;
                else if (wr_data[i])
                    data_q[i] <= bus_req.wdata;
            end

            // register filled since the last start
            always_ff @(posedge clk_sys)
            begin
                if (!resetn || port_clr)
                    written_q[i] <= 1'b0;
                else if (wr_data[i])
                    written_q[i] <= 1'b1;
                else if (start)
                    written_q[i] <= 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // transfer sequencer
    stp_state_e state_q;
    logic [2:0] idx_q;
    logic [2:0] last_idx;
    logic all_written;
    logic sh_ready;
    logic sh_idle;
    logic sh_load;
    logic [7:0] sh_byte;
    logic stop_port;
    logic [2:0] load_idx;

    assign last_idx = last_index(ctrl_q.count);
    assign all_written = (written_q & regs_needed(ctrl_q.count)) == regs_needed(ctrl_q.count);
    assign stop_port = !ctrl_q.enable || port_clr;
    assign start = state_q == STP_ST_IDLE && ctrl_q.enable && all_written;

    // next byte to hand to the shifter
    always_comb
    begin
        load_idx = idx_q + 3'd1;
        sh_load = 1'b0;
        if (start)
        begin
            load_idx = 3'd0;
            sh_load = 1'b1;
        end
        else if (state_q == STP_ST_SEND && sh_ready && idx_q != last_idx)
            sh_load = 1'b1; // back to back
    end

    // byte select, low half first
    assign sh_byte = load_idx[0] ? data_q[load_idx[2:1]][15:8] : data_q[load_idx[2:1]][7:0];

    // state and byte index
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || stop_port)
        begin
            state_q <= STP_ST_IDLE;
            idx_q <= 3'd0;
        end
        else
        begin
            unique case (state_q)
                STP_ST_IDLE:
                    if (start)
                    begin
                        state_q <= STP_ST_SEND;
                        idx_q <= 3'd0;
                    end
                STP_ST_SEND:
                    if (sh_ready)
                    begin
                        if (idx_q == last_idx)
                            state_q <= STP_ST_DRAIN;
                        else
                            idx_q <= load_idx;
                    end
                STP_ST_DRAIN:
                    if (sh_idle)
                        state_q <= STP_ST_IDLE;
                default:
                    state_q <= STP_ST_IDLE;
            endcase
        end
    end

    // packet shifter
    stp_packet_shift u_shift
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(stop_port),
        .baud_tick(baud_tick),
        .load(sh_load),
        .load_byte(sh_byte),
        .ready(sh_ready),
        .idle(sh_idle),
        .tx_line(test_line)
    );

    // ==========================================================
    // read path
    logic [3:0] state_bits;
    logic [15:0] rdata_q;
    logic [15:0] ctrl_word;

    // byte number being sent, zero when quiet
    assign state_bits = (state_q == STP_ST_IDLE) ? 4'd0 : {1'b0, idx_q} + 4'd1;
    assign ctrl_word = {7'd0, state_bits, ctrl_q.count, ctrl_q.port_reset, ctrl_q.enable};

    // read data for one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !bus_req.rd)
            rdata_q <= '0;
        else
        begin
            unique case (bus_req.addr)
                STP_ADDR_CONTROL: rdata_q <= ctrl_word;
                STP_ADDR_BYTES_ONE_TWO: rdata_q <= data_q[0];
                STP_ADDR_BYTES_THREE_FOUR: rdata_q <= data_q[1];
                STP_ADDR_BYTES_FIVE_SIX: rdata_q <= data_q[2];
                default: rdata_q <= '0; // keys and unmapped read zero
            endcase
        end
    end

    assign rdata = rdata_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_unarmed_ctrl_write;
        wr_control && !key_armed_q;
    endsequence

    sequence s_pending_broken;
        pend_q && any_access && !(wr_key_second && bus_req.wdata == STP_KEY_SECOND);
    endsequence

    sequence s_full_unlock;
        wr_key_first && bus_req.wdata == STP_KEY_FIRST ##1 wr_control ##1
            (wr_key_second && bus_req.wdata == STP_KEY_SECOND && !pend_val_q.port_reset);
    endsequence

    property p_no_first_key;
        s_unarmed_ctrl_write |=> !pend_q ##1 $stable(ctrl_q);
    endproperty
    a_no_first_key: assert property (p_no_first_key) else $error("unarmed write kept");

    property p_no_second_key;
        s_pending_broken |=> $stable(ctrl_q) && !pend_q;
    endproperty
    a_no_second_key: assert property (p_no_second_key) else $error("broken unlock wrote");

    property p_unlock_commits;
        s_full_unlock |=> ctrl_q == $past(pend_val_q);
    endproperty
    a_unlock_commits: assert property (p_unlock_commits) else $error("unlock lost");

    property p_port_reset;
        port_clr |=> ctrl_q == '0 && written_q == 3'b000 && state_q == STP_ST_IDLE;
    endproperty
    a_port_reset: assert property (p_port_reset) else $error("port reset incomplete");

    property p_wait_for_data;
        state_q == STP_ST_IDLE && !all_written |=> state_q == STP_ST_IDLE;
    endproperty
    a_wait_for_data: assert property (p_wait_for_data) else $error("sent before data");

    property p_state_read;
        bus_req.rd && bus_req.addr == STP_ADDR_CONTROL && state_q != STP_ST_IDLE
            && ctrl_q.enable && !commit |=> rdata[8:5] != 4'd0;
    endproperty
    a_state_read: assert property (p_state_read) else $error("busy reads zero");

    property p_disable_idles;
        !ctrl_q.enable ##1 !ctrl_q.enable |-> test_line && state_q == STP_ST_IDLE;
    endproperty
    a_disable_idles: assert property (p_disable_idles) else $error("disabled pin busy");

    property p_last_byte;
        state_q == STP_ST_SEND && sh_ready && idx_q == last_idx && !stop_port
            |-> !sh_load ##1 state_q == STP_ST_DRAIN;
    endproperty
    a_last_byte: assert property (p_last_byte) else $error("byte count wrong");

    property p_rdata_quiet;
        !bus_req.rd |=> rdata == 16'h0000;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data lingers");

    property p_data_mid;
        wr_data[1] |=> data_q[1] == $past(bus_req.wdata);
    endproperty
    a_data_mid: assert property (p_data_mid) else $error("third-fourth bytes lost");

    property p_data_top;
        wr_data[2] |=> data_q[2] == $past(bus_req.wdata);
    endproperty
    a_data_top: assert property (p_data_top) else $error("fifth-sixth bytes lost");

    property p_first_byte;
        start |-> sh_load && sh_byte == data_q[0][7:0];
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("first byte not low");

    property p_gapless;
        state_q == STP_ST_SEND && sh_ready && idx_q != last_idx && !stop_port |-> sh_load;
    endproperty
    a_gapless: assert property (p_gapless) else $error("gap between packets");

    property p_quiet_after;
        state_q == STP_ST_DRAIN && sh_idle && !stop_port |=> state_bits == 4'd0;
    endproperty
    a_quiet_after: assert property (p_quiet_after) else $error("state bits stuck");

    property p_held_when_off;
        !ctrl_q.enable |=> state_q == STP_ST_IDLE;
    endproperty
    a_held_when_off: assert property (p_held_when_off) else $error("sent while off");

endmodule : stp_serial_test_port

/* sim/stp_rx_model.sv */
// Purpose: diagnostic receiver that listens on the test pin
// Assumes: the line is sampled at each baud tick, one bit per tick
// Notes: reports every packet whole; the bench judges its contents
`timescale 1ns/100ps

module stp_rx_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // line side
    input wire logic baud_tick,
    input wire logic line,
    // decoded packet: stop bits, parity, byte
    output logic got,
    output logic [10:0] pkt
);
    int cnt;
    logic [10:0] sh;

    // ==========================================================
    // start detect, then eleven more samples per packet
    always @(posedge clk_sys)
    begin
        got <= 1'b0;
        if (!resetn)
        begin
            cnt = 0;
        end
        else if (baud_tick)
        begin
            if (cnt == 0 && line == 1'b0)
                cnt = 1;
            else if (cnt > 0)
            begin
                sh = {line, sh[10:1]}; // lsb first
                cnt++;
                if (cnt == 12)
                begin
                    got <= 1'b1;
                    pkt <= sh;
                    cnt = 0;
                end
            end
        end
    end
endmodule : stp_rx_model

/* sim/stp_serial_test_port_tb_top.sv */
// Purpose: self-checking bench for the serial test port
// Assumes: baud ticks made here with random spacing
// Notes: expected bytes come from a queue model of the data registers
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module serial_test_tx_port_tb_top;
    import stp_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    stp_bus_req_s bus_req = '0;
    logic baud_tick = 1'b0;
    logic [15:0] rdata;
    logic test_line;
    logic got;
    logic [10:0] pkt;
    logic [10:0] rx_q[$];
    int exp_q[$];
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'hf67f28f4;
    int tcnt = 0;
    logic chk_tick = 1'b1;
    logic prev_line = 1'b1;
    logic tick_d = 1'b0;
    logic [15:0] v;
    logic [15:0] dv[3];
    logic [31:0] da[3] = '{STP_ADDR_BYTES_ONE_TWO, STP_ADDR_BYTES_THREE_FOUR,
        STP_ADDR_BYTES_FIVE_SIX};
    logic [15:0] k1s[4] = '{16'h0006, STP_KEY_FIRST, STP_KEY_FIRST, STP_KEY_FIRST};
    logic [15:0] k2s[4] = '{STP_KEY_SECOND, STP_KEY_SECOND, STP_KEY_SECOND, 16'h00b8};
    int mds[4] = '{0, 1, 2, 0};

    // ==========================================================
    // clock, baud timer and instances
    always #50 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        if (tcnt == 0)
        begin
            baud_tick <= 1'b1;
            tcnt <= 2 + {$random(seed)} % 6;
        end
        else
        begin
            baud_tick <= 1'b0;
            tcnt <= tcnt - 1;
        end
    end

    stp_serial_test_port i_dut (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
        .rdata(rdata), .baud_tick(baud_tick), .test_line(test_line));

    stp_rx_model i_rx (.clk_sys(clk_sys), .resetn(resetn), .baud_tick(baud_tick),
        .line(test_line), .got(got), .pkt(pkt));

    // collect packets and watch that the line only moves after a tick
    always @(posedge clk_sys)
    begin
        if (got)
            rx_q.push_back(pkt);
        if (resetn && chk_tick && test_line !== prev_line)
            `CHK("tick step", 1'b1, tick_d)
        prev_line <= test_line;
        tick_d <= baud_tick;
    end

    // ==========================================================
    // bus tasks
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // mode 0 back to back, 1 a read inside, 2 no first key, 3 idle gaps between writes
    task automatic unlock(input logic [15:0] c, input logic [15:0] k1,
        input logic [15:0] k2, input int md);
        logic [15:0] t;
        if (md == 0)
        begin
            @(posedge clk_sys);
            bus_req <= '{addr: STP_ADDR_UNLOCK_FIRST, wdata: k1, wr: 1'b1, rd: 1'b0};
            @(posedge clk_sys);
            bus_req <= '{addr: STP_ADDR_CONTROL, wdata: c, wr: 1'b1, rd: 1'b0};
            @(posedge clk_sys);
            bus_req <= '{addr: STP_ADDR_UNLOCK_SECOND, wdata: k2, wr: 1'b1, rd: 1'b0};
            @(posedge clk_sys);
            bus_req.wr <= 1'b0;
        end
        else
        begin
            if (md != 2)
                wr(STP_ADDR_UNLOCK_FIRST, k1);
            if (md == 1)
                rd(STP_ADDR_BYTES_ONE_TWO, t);
            wr(STP_ADDR_CONTROL, c);
            wr(STP_ADDR_UNLOCK_SECOND, k2);
        end
    endtask : unlock

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic wait_rx(input int n);
        int i;
        for (i = 0; i < 4000 && rx_q.size() < n; i++)
            @(posedge clk_sys);
        if (rx_q.size() < n)
        begin
            num_errors++;
            final_report();
        end
    endtask : wait_rx

    // ==========================================================
    // main sequence
    initial
    begin
        int n;
        int b;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        `CHK("idle line", 1'b1, test_line)
        rd(STP_ADDR_CONTROL, v);
        `CHK("ctrl reset", STP_CTRL_RESET, v)
        for (b = 0; b < 3; b++)
        begin
            rd(da[b], v);
            `CHK("data reset", STP_DATA_RESET, v)
            dv[b] = $random(seed);
            wr(da[b], dv[b]);
            rd(da[b], v);
            `CHK("data rw", dv[b], v)
        end
        rd(32'hffff_08a0, v);
        `CHK("unmapped", 16'h0000, v)
        // committing the reset bit clears control and data
        unlock(16'h0002, STP_KEY_FIRST, STP_KEY_SECOND, 0);
        rd(STP_ADDR_CONTROL, v);
        `CHK("ctrl after reset", 16'h0000, v)
        rd(STP_ADDR_BYTES_ONE_TWO, v);
        `CHK("data after reset", 16'h0000, v)
        // broken unlock sequences leave control untouched
        for (b = 0; b < 4; b++)
        begin
            unlock(16'h0011, k1s[b], k2s[b], mds[b]);
            rd(STP_ADDR_CONTROL, v);
            `CHK("locked ctrl", 16'h0000, v)
        end
        // every count code from 000 to 101, with data random
        for (n = 1; n <= 6; n++)
        begin
            unlock(16'((n - 1) << 2 | 1), STP_KEY_FIRST, STP_KEY_SECOND, (n % 2) * 3);
            rx_q.delete();
            exp_q.delete();
            for (b = 0; b < 3; b++)
                dv[b] = $random(seed);
            for (b = 0; b < n; b++)
                exp_q.push_back((dv[b / 2] >> (8 * (b % 2))) & 8'hff);
            wr(da[0], dv[0]);
            if (n >= 3)
            begin
                repeat (30) @(posedge clk_sys);
                `CHK("no early start", 1'b1, test_line)
                `CHK("no early packet", 0, rx_q.size())
            end
            for (b = 1; b < (n + 1) / 2; b++)
                wr(da[b], dv[b]);
            repeat (15) @(posedge clk_sys);
            rd(STP_ADDR_CONTROL, v);
            `CHK("busy state", 1'b1, v[8:5] != 4'h0)
            wait_rx(n);
            for (b = 0; b < n; b++)
            begin
                `CHK("byte", exp_q[b][7:0], rx_q[b][7:0])
                `CHK("parity", ^exp_q[b][7:0], rx_q[b][8])
                `CHK("stop bits", 2'b11, rx_q[b][10:9])
            end
            repeat (20) @(posedge clk_sys);
            `CHK("byte count", n, rx_q.size())
            rd(STP_ADDR_CONTROL, v);
            `CHK("ctrl done", 16'((n - 1) << 2 | 1), v)
        end
        // disable in mid packet, zero data keeps the line low until then
        unlock(16'h0001, STP_KEY_FIRST, STP_KEY_SECOND, 0);
        wr(da[0], 16'h0000);
        for (b = 0; b < 200 && test_line !== 1'b0; b++)
            @(posedge clk_sys);
        `CHK("started", 1'b0, test_line)
        repeat (12) @(posedge clk_sys);
        chk_tick <= 1'b0;
        unlock(16'h0000, STP_KEY_FIRST, STP_KEY_SECOND, 0);
        for (b = 0; b < 100; b++)
        begin
            @(posedge clk_sys);
            #1 `CHK("stopped line", 1'b1, test_line)
        end
        rd(STP_ADDR_CONTROL, v);
        `CHK("ctrl off", 16'h0000, v)
        final_report();
    end
endmodule : serial_test_tx_port_tb_top
